// ==== hw/msad_cfg.svh ====
// Address map constants for the memory space address decoder
`ifndef MSAD_CFG_SVH
`define MSAD_CFG_SVH

// Region bases and sizes, byte addresses
`define MSAD_L1I_BASE 32'hffa0_0000
`define MSAD_L1I_SIZE 32'h0001_0000
`define MSAD_L1I_CACHE_OFS 32'h0000_c000
`define MSAD_L1D_A_BASE 32'hff80_0000
`define MSAD_L1D_B_BASE 32'hff90_0000
`define MSAD_L1D_BANK_SIZE 32'h0000_8000
`define MSAD_SCR_BASE 32'hffb0_0000
`define MSAD_SCR_SIZE 32'h0000_1000
`define MSAD_SYS_REG_BASE 32'hffc0_0000
`define MSAD_CORE_REG_BASE 32'hffe0_0000
`define MSAD_REG_BLK_SIZE 32'h0020_0000
`define MSAD_BOOT_BASE 32'hef00_0000
`define MSAD_BOOT_SIZE 32'h0000_0800
`define MSAD_ASYNC_BASE 32'h2000_0000
`define MSAD_ASYNC_SEG 32'h0010_0000
`define MSAD_ASYNC_SEL_LSB 20
`define MSAD_SDRAM_BASE 32'h0000_0000
`define MSAD_SDRAM_MIN 32'h0100_0000
`define MSAD_SDRAM_MAX_CODE 3'h5
`define MSAD_SDRAM_MIN_LG 24

// SDRAM internal banks and row field
`define MSAD_SDRAM_BANKS 4
`define MSAD_SDRAM_BANK_W 2
`define MSAD_ROW_LSB 10
`define MSAD_ROW_W 13

`endif

// ==== hw/msad_pkg.sv ====
// Types shared by the memory space address decoder
package msad_pkg;

  typedef enum logic [2:0] {
    MSAD_MODE_USER = 3'h1,
    MSAD_MODE_SUPER = 3'h2,
    MSAD_MODE_EMUL = 3'h4
  } msad_mode_e;

  typedef enum logic [9:0] {
    MSAD_TGT_NONE = 10'h001,
    MSAD_TGT_L1I = 10'h002,
    MSAD_TGT_L1D_A = 10'h004,
    MSAD_TGT_L1D_B = 10'h008,
    MSAD_TGT_SCR = 10'h010,
    MSAD_TGT_CORE_REG = 10'h020,
    MSAD_TGT_SYS_REG = 10'h040,
    MSAD_TGT_SDRAM = 10'h080,
    MSAD_TGT_ASYNC = 10'h100,
    MSAD_TGT_BOOT = 10'h200
  } msad_target_e;

endpackage

// ==== hw/msad_decoder.sv ====
// Memory space address decoder with privilege and configuration checks
`timescale 1ns/1ns
`default_nettype none
`include "msad_cfg.svh"

// Contract
// - One byte-addressed 4G space, chosen by a 32-bit address.
// - No separate I/O space; control registers are reached by address only.
// - Two control register blocks near the top: core and peripherals.
// - Control blocks need supervisor; peripheral masters see them as reserved.
// - Modes user, supervisor, emulation; user denied system resources.
// - L1 instruction 64K, instructions only; 16K may be cache.
// - Two L1 data banks of 32K, each cache or SRAM.
// - 4K scratchpad is data SRAM only, never cache, never fetched.
// - External accesses go to the 16-bit external bus unit.
// - SDRAM up to 512M, 4 internal banks, one open row each.
// - Four asynchronous banks, each a fixed 1M segment.
// - With boot from ROM, first fetch after reset goes to boot ROM unless it comes in the first two cycles, before the strap is synchronised.
module msad_decoder
  import msad_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int ASYNC_BANKS = 4
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Request from core or DMA master
  input wire logic req_valid_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_write_i,
  input wire logic req_fetch_i,
  input wire logic req_periph_i,
  input wire msad_pkg::msad_mode_e req_mode_i,
  // Memory configuration from same-clock logic
  input wire logic cfg_icache_en_i,
  input wire logic cfg_dbank_a_cache_i,
  input wire logic cfg_dbank_b_cache_i,
  input wire logic cfg_dbank_b_present_i,
  input wire logic [2:0] cfg_sdram_size_i,
  input wire logic [ASYNC_BANKS-1:0] cfg_async_en_i,
  // Boot strap pin
  input wire logic boot_rom_sel_i,
  // Routed answer
  output logic resp_valid_o,
  output logic resp_error_o,
  output msad_pkg::msad_target_e resp_target_o,
  output logic [ADDR_W-1:0] resp_offset_o,
  output logic resp_write_o,
  output logic resp_ext_o,
  output logic [1:0] resp_async_bank_o,
  output logic [1:0] resp_sdram_bank_o,
  output logic resp_row_hit_o,
  output logic resp_boot_redirect_o
);

  import msad_pkg::*;

  // Boot strap synchroniser; first flop feeds only the second
  logic boot_meta;
  logic boot_sync;
  logic first_fetch;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      boot_meta <= 1'b0;
      boot_sync <= 1'b0;
    end
    else
    begin
      boot_meta <= boot_rom_sel_i;
      boot_sync <= boot_meta;
    end
  end

  // Boot redirect of the first fetch
  wire redirect = req_valid_i && req_fetch_i && first_fetch && boot_sync;
  wire [ADDR_W-1:0] addr = redirect ? `MSAD_BOOT_BASE : req_addr_i;

  // Privilege: emulation counts as supervisor; user and DMA masters do not
  wire privileged = (req_mode_i == MSAD_MODE_SUPER) || (req_mode_i == MSAD_MODE_EMUL);
  wire reg_allowed = privileged && !req_periph_i;

  // Region hits over the single flat space
  wire [ADDR_W-1:0] ofs_l1i = addr - `MSAD_L1I_BASE;
  wire [ADDR_W-1:0] ofs_da = addr - `MSAD_L1D_A_BASE;
  wire [ADDR_W-1:0] ofs_db = addr - `MSAD_L1D_B_BASE;
  wire [ADDR_W-1:0] ofs_scr = addr - `MSAD_SCR_BASE;
  wire [ADDR_W-1:0] ofs_core = addr - `MSAD_CORE_REG_BASE;
  wire [ADDR_W-1:0] ofs_sys = addr - `MSAD_SYS_REG_BASE;
  wire [ADDR_W-1:0] ofs_boot = addr - `MSAD_BOOT_BASE;
  wire [ADDR_W-1:0] ofs_async = addr - `MSAD_ASYNC_BASE;
  wire [ADDR_W-1:0] ofs_sdram = addr - `MSAD_SDRAM_BASE;

  // Offsets wrap below a base, so each hit tests the lower bound too
  wire hit_l1i = (addr >= `MSAD_L1I_BASE) && (ofs_l1i < `MSAD_L1I_SIZE);
  wire hit_da = (addr >= `MSAD_L1D_A_BASE) && (ofs_da < `MSAD_L1D_BANK_SIZE);
  wire hit_db = (addr >= `MSAD_L1D_B_BASE) && (ofs_db < `MSAD_L1D_BANK_SIZE);
  wire hit_scr = (addr >= `MSAD_SCR_BASE) && (ofs_scr < `MSAD_SCR_SIZE);
  wire hit_core = (addr >= `MSAD_CORE_REG_BASE) && (ofs_core < `MSAD_REG_BLK_SIZE);
  wire hit_sys = (addr >= `MSAD_SYS_REG_BASE) && (ofs_sys < `MSAD_REG_BLK_SIZE);
  wire hit_boot = (addr >= `MSAD_BOOT_BASE) && (ofs_boot < `MSAD_BOOT_SIZE);

  // Async banks sit in fixed 1M segments, even when the device is smaller
  wire [ADDR_W-1:0] async_span = ADDR_W'(`MSAD_ASYNC_SEG * ASYNC_BANKS);
  wire in_async = (addr >= `MSAD_ASYNC_BASE) && (ofs_async < async_span);
  wire [1:0] async_bank = ofs_async[`MSAD_ASYNC_SEL_LSB +: 2];
  wire [ADDR_W-1:0] async_ofs = ofs_async & (`MSAD_ASYNC_SEG - 32'h1);
  wire hit_async = in_async && cfg_async_en_i[async_bank];

  // SDRAM size is 16M shifted by the code, capped at 512M
  wire [2:0] size_code = (cfg_sdram_size_i > `MSAD_SDRAM_MAX_CODE) ?
                         `MSAD_SDRAM_MAX_CODE : cfg_sdram_size_i;
  wire [ADDR_W-1:0] sdram_size = `MSAD_SDRAM_MIN << size_code;
  wire hit_sdram = (addr >= `MSAD_SDRAM_BASE) && (ofs_sdram < sdram_size);

  // Internal bank is the top two address bits inside the programmed size
  logic [1:0] sdram_bank;
  always_comb
  begin
    sdram_bank = 2'h0;
    for (int i = 0; i <= `MSAD_SDRAM_MAX_CODE; i++)
    begin
      if (size_code == 3'(i))
      begin
        sdram_bank = ofs_sdram[`MSAD_SDRAM_MIN_LG + i - `MSAD_SDRAM_BANK_W +: 2];
      end
    end
  end
  wire [`MSAD_ROW_W-1:0] sdram_row = ofs_sdram[`MSAD_ROW_LSB +: `MSAD_ROW_W];

  // Configuration checks; cache ways are not reachable as plain memory
  wire l1i_cache_area = cfg_icache_en_i && (ofs_l1i >= `MSAD_L1I_CACHE_OFS);
  wire ok_l1i = hit_l1i && req_fetch_i && !l1i_cache_area;
  wire ok_da = hit_da && !req_fetch_i && !cfg_dbank_a_cache_i;
  wire ok_db = hit_db && !req_fetch_i && cfg_dbank_b_present_i && !cfg_dbank_b_cache_i;
  wire ok_scr = hit_scr && !req_fetch_i;
  wire ok_core = hit_core && !req_fetch_i && reg_allowed;
  wire ok_sys = hit_sys && !req_fetch_i && reg_allowed;
  wire ok_boot = hit_boot && !req_write_i;

  // Target selection; anything not claimed is reserved
  // Disjoint regions make the priority order below harmless
  logic tgt_ok;
  msad_target_e tgt;
  logic [ADDR_W-1:0] tgt_ofs;
  always_comb
  begin
    tgt_ok = 1'b1;
    tgt = MSAD_TGT_NONE;
    tgt_ofs = addr;
    if (ok_l1i)
    begin
      tgt = MSAD_TGT_L1I;
      tgt_ofs = ofs_l1i;
    end
    else if (ok_da)
    begin
      tgt = MSAD_TGT_L1D_A;
      tgt_ofs = ofs_da;
    end
    else if (ok_db)
    begin
      tgt = MSAD_TGT_L1D_B;
      tgt_ofs = ofs_db;
    end
    else if (ok_scr)
    begin
      tgt = MSAD_TGT_SCR;
      tgt_ofs = ofs_scr;
    end
    else if (ok_core)
    begin
      tgt = MSAD_TGT_CORE_REG;
      tgt_ofs = ofs_core;
    end
    else if (ok_sys)
    begin
      tgt = MSAD_TGT_SYS_REG;
      tgt_ofs = ofs_sys;
    end
    else if (ok_boot)
    begin
      tgt = MSAD_TGT_BOOT;
      tgt_ofs = ofs_boot;
    end
    else if (hit_sdram)
    begin
      tgt = MSAD_TGT_SDRAM;
      tgt_ofs = ofs_sdram;
    end
    else if (hit_async)
    begin
      tgt = MSAD_TGT_ASYNC;
      tgt_ofs = async_ofs;
    end
    else
    begin
      tgt_ok = 1'b0;
    end
  end

  // External targets leave through the external bus unit
  wire is_sdram = (tgt == MSAD_TGT_SDRAM);
  wire is_ext = is_sdram || (tgt == MSAD_TGT_ASYNC);

  // Open row per internal SDRAM bank
  // Rows close here only on reset; precharge and refresh belong to the controller
  logic [`MSAD_ROW_W-1:0] open_row [`MSAD_SDRAM_BANKS];
  logic [`MSAD_SDRAM_BANKS-1:0] row_open;
  wire bank_open = row_open[sdram_bank];
  wire [`MSAD_ROW_W-1:0] bank_row = open_row[sdram_bank];
  wire row_hit = bank_open && (bank_row == sdram_row);
  wire row_update = req_valid_i && is_sdram;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      row_open <= '0;
      for (int b = 0; b < `MSAD_SDRAM_BANKS; b++)
      begin
        open_row[b] <= '0;
      end
    end
    else if (row_update)
    begin
      row_open[sdram_bank] <= 1'b1;
      open_row[sdram_bank] <= sdram_row;
    end
  end

  // First fetch after reset; only fetches clear it
  // A fetch with the strap low spends the redirect as well
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      first_fetch <= 1'b1;
    else if (req_valid_i && req_fetch_i)
      first_fetch <= 1'b0;
  end

  // Next answer values; an idle or blocked cycle routes nowhere
  wire next_error = req_valid_i && !tgt_ok;
  msad_target_e next_target;
  assign next_target = req_valid_i ? tgt : MSAD_TGT_NONE;
  wire next_ext = req_valid_i && is_ext;
  wire next_row_hit = req_valid_i && is_sdram && row_hit;

  // Answer handshake and routing, one cycle after each request
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      resp_valid_o <= 1'b0;
      resp_error_o <= 1'b0;
      resp_target_o <= MSAD_TGT_NONE;
      resp_write_o <= 1'b0;
    end
    else
    begin
      resp_valid_o <= req_valid_i;
      resp_error_o <= next_error;
      resp_target_o <= next_target;
      resp_write_o <= req_write_i;
    end
  end

  // Offset inside the chosen region; raw address when blocked
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      resp_offset_o <= '0;
      resp_ext_o <= 1'b0;
    end
    else
    begin
      resp_offset_o <= tgt_ofs;
      resp_ext_o <= next_ext;
    end
  end

  // Bank details and boot redirect flag; the bank fields only meaningful while the target is external
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      resp_async_bank_o <= 2'h0;
      resp_sdram_bank_o <= 2'h0;
      resp_row_hit_o <= 1'b0;
      resp_boot_redirect_o <= 1'b0;
    end
    else
    begin
      resp_async_bank_o <= async_bank;
      resp_sdram_bank_o <= sdram_bank;
      resp_row_hit_o <= next_row_hit;
      resp_boot_redirect_o <= redirect;
    end
  end

endmodule
`default_nettype wire

// ==== verification/msad_core_model.sv ====
// Request side model of the core fetch and load/store ports
`timescale 1ns/1ns
`default_nettype none
module msad_core_model
  import msad_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Request to the decoder
  output logic req_valid_o,
  output logic [31:0] req_addr_o,
  output logic req_write_o,
  output logic req_fetch_o,
  output logic req_periph_o,
  output msad_pkg::msad_mode_e req_mode_o
);
  initial req_valid_o = 0;
  initial req_addr_o = 0;

  // Called at the falling edge; an idle bus shows no stale address
  task automatic issue(input logic v, input logic [31:0] a, input logic w, f, p,
                       input msad_mode_e m);
    req_valid_o = v;
    req_addr_o = v ? a : ~req_addr_o;
    req_write_o = w;
    req_fetch_o = f;
    req_periph_o = p;
    req_mode_o = m;
  endtask
endmodule
`default_nettype wire

// ==== verification/msad_decoder_asserts.sv ====
// Port checks for the memory space address decoder
`timescale 1ns/1ns
`default_nettype none
module msad_decoder_asserts
  import msad_pkg::*;
(
  // Clock and request
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire logic [31:0] req_addr_i,
  input wire logic req_fetch_i,
  input wire logic req_periph_i,
  input wire msad_pkg::msad_mode_e req_mode_i,
  // Answer
  input wire logic resp_valid_o,
  input wire logic resp_error_o,
  input wire msad_pkg::msad_target_e resp_target_o,
  input wire logic resp_ext_o,
  input wire logic [1:0] resp_async_bank_o,
  input wire logic resp_boot_redirect_o
);
  logic [1:0] seg_q;
  always_ff @(posedge clk_i) seg_q <= req_addr_i[21:20];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_answer_next: assert property (req_valid_i |=> resp_valid_o)
    else $error("request not answered");
  a_idle_quiet: assert property (!req_valid_i |=> !resp_valid_o && resp_target_o == MSAD_TGT_NONE)
    else $error("answer without request");
  a_error_no_target: assert property (resp_error_o |-> resp_valid_o && resp_target_o == MSAD_TGT_NONE)
    else $error("blocked access still routed");
  a_reg_privilege: assert property (req_valid_i && req_addr_i[31:22] == 10'h3ff &&
    (req_mode_i == MSAD_MODE_USER || req_periph_i) |=> resp_error_o || resp_boot_redirect_o)
    else $error("register block reached without privilege");
  a_scratch_fetch: assert property (req_valid_i && req_fetch_i &&
    req_addr_i[31:12] == 20'hffb00 |=> resp_error_o || resp_boot_redirect_o)
    else $error("fetch from scratchpad allowed");
  a_l1i_data: assert property (req_valid_i && !req_fetch_i &&
    req_addr_i[31:16] == 16'hffa0 |=> resp_error_o)
    else $error("data access to instruction memory allowed");
  a_ext_route: assert property (resp_valid_o |->
    resp_ext_o == (resp_target_o inside {MSAD_TGT_SDRAM, MSAD_TGT_ASYNC}))
    else $error("external flag wrong");
  a_async_segment: assert property (req_valid_i && req_addr_i[31:22] == 10'h080 |=>
    resp_error_o || resp_boot_redirect_o ||
    (resp_target_o == MSAD_TGT_ASYNC && resp_async_bank_o == seg_q))
    else $error("async segment wrong");
  a_redirect_boot: assert property (resp_boot_redirect_o |->
    resp_valid_o && resp_target_o == MSAD_TGT_BOOT)
    else $error("redirected fetch not sent to boot ROM");
endmodule
bind msad_decoder msad_decoder_asserts u_msad_decoder_asserts (.clk_i, .reset_n_i,
  .req_valid_i, .req_addr_i, .req_fetch_i, .req_periph_i, .req_mode_i, .resp_valid_o,
  .resp_error_o, .resp_target_o, .resp_ext_o, .resp_async_bank_o, .resp_boot_redirect_o);
`default_nettype wire

// ==== verification/memory_space_address_decoder_tb_top.sv ====
// Self-checking bench for the memory space address decoder
`timescale 1ns/1ns
`default_nettype none
module memory_space_address_decoder_tb_top;
  import msad_pkg::*;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic rv, rw, rf, rp, ic = 0, ca = 0, cb = 0, bp = 1, strap = 1, ff = 1, mix = 0;
  logic [31:0] ra, pa, e_ofs;
  msad_mode_e rm;
  logic [2:0] sz = 0;
  logic [3:0] aen = 4'hf, open = 0;
  logic ov, oe, ow, ox, oh, od, e_v = 0, e_err, e_hit, e_redir, e_w;
  msad_target_e ot;
  logic [31:0] oo;
  logic [1:0] oa, ob, e_bank, e_ab;
  logic [9:0] e_tgt;
  logic [12:0] rows [4];
  logic [31:0] base [10] = '{32'hffa0_0000, 32'hff80_0000, 32'hff90_0000, 32'hffb0_0000,
    32'hffc0_0000, 32'hffe0_0000, 32'hef00_0000, 32'h0, 32'h2000_0000, 32'h1000_0000};
  int bad_count = 0;
  int n_compared = 0;
  always #25 clk_i = ~clk_i;

  msad_core_model u_msad_core_model (.clk_i, .req_valid_o(rv), .req_addr_o(ra),
    .req_write_o(rw), .req_fetch_o(rf), .req_periph_o(rp), .req_mode_o(rm));
  msad_decoder u_msad_decoder (.clk_i, .reset_n_i, .req_valid_i(rv), .req_addr_i(ra),
    .req_write_i(rw), .req_fetch_i(rf), .req_periph_i(rp), .req_mode_i(rm),
    .cfg_icache_en_i(ic), .cfg_dbank_a_cache_i(ca), .cfg_dbank_b_cache_i(cb),
    .cfg_dbank_b_present_i(bp), .cfg_sdram_size_i(sz), .cfg_async_en_i(aen),
    .boot_rom_sel_i(strap), .resp_valid_o(ov), .resp_error_o(oe), .resp_target_o(ot),
    .resp_offset_o(oo), .resp_write_o(ow), .resp_ext_o(ox), .resp_async_bank_o(oa),
    .resp_sdram_bank_o(ob), .resp_row_hit_o(oh), .resp_boot_redirect_o(od));

  task automatic chk(input string n, input logic [31:0] s, x);
    n_compared++;
    if (s !== x)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  // Blocked accesses lose their target and report the raw address
  task automatic put(input logic [9:0] t, input logic [31:0] o, input logic e);
    e_err = e;
    e_tgt = e ? 10'h001 : t;
    e_ofs = e ? pa : o;
  endtask

  task automatic predict(input logic v, input logic [31:0] a, input logic w, f, p, m1);
    int lg;
    lg = 24 + (sz > 5 ? 5 : sz);
    e_v = v;
    e_w = w;
    e_redir = v && f && ff && strap;
    if (v && f) ff = 0;
    pa = e_redir ? 32'hef00_0000 : a;
    e_ab = pa[21:20];
    if (pa[31:16] == 16'hffa0) put(10'h002, pa & 32'hffff, !f || (ic && pa[15:14] == 2'h3));
    else if (pa[31:15] == 17'h1ff00) put(10'h004, pa & 32'h7fff, f || ca);
    else if (pa[31:15] == 17'h1ff20) put(10'h008, pa & 32'h7fff, f || cb || !bp);
    else if (pa[31:12] == 20'hffb00) put(10'h010, pa & 32'hfff, f);
    else if (pa[31:21] == 11'h7ff) put(10'h020, pa & 32'h1f_ffff, f || p || m1);
    else if (pa[31:21] == 11'h7fe) put(10'h040, pa & 32'h1f_ffff, f || p || m1);
    else if (pa[31:11] == 21'h1de000) put(10'h200, pa & 32'h7ff, w);
    else if (pa < (32'h1 << lg)) put(10'h080, pa, 0);
    else if (pa[31:22] == 10'h080) put(10'h100, pa & 32'hf_ffff, !aen[pa[21:20]]);
    else put(10'h001, pa, 1);
    if (!v || e_tgt != 10'h080) return;
    e_bank = 2'(pa >> (lg - 2));
    e_hit = open[e_bank] && rows[e_bank] == pa[22:10];
    open[e_bank] = 1;
    rows[e_bank] = pa[22:10];
  endtask

  task automatic step(input logic v, input logic [31:0] a, input logic w, f, p,
                      input logic [2:0] m);
    @(negedge clk_i);
    chk("valid", ov, e_v);
    chk("target", ot, e_v ? e_tgt : 10'h001);
    if (e_v)
    begin
      chk("error", oe, e_err);
      chk("offset", oo, e_ofs);
      chk("write", ow, e_w);
      chk("ext", ox, e_tgt inside {10'h080, 10'h100});
      chk("redirect", od, e_redir);
      if (e_tgt == 10'h080) chk("sdram", {ob, oh}, {e_bank, e_hit});
      if (e_tgt == 10'h100) chk("segment", oa, e_ab);
    end
    if (mix) {ic, ca, cb, bp, sz, aen} = 11'($urandom);
    predict(v, a, w, f, p, m == 3'h1);
    u_msad_core_model.issue(v, a, w, f, p, msad_mode_e'(m));
  endtask

  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    logic [31:0] a;
    logic f;
    void'($urandom(32'he2b7));
    a = 0;
    // A second reset in mid-run must close all rows and rearm the boot redirect
    for (int r = 0; r < 2; r++)
    begin
      @(negedge clk_i);
      reset_n_i = 0;
      u_msad_core_model.issue(0, 0, 0, 0, 0, MSAD_MODE_SUPER);
      e_v = 0;
      ff = 1;
      open = 0;
      repeat (9) @(negedge clk_i);
      reset_n_i = 1;
      repeat (3) step(0, 0, 0, 0, 0, 3'h2);
      // First fetch lands in boot ROM, the next one does not
      step(1, 32'h0, 0, 1, 0, 3'h2);
      step(1, 32'hffa0_0000, 0, 1, 0, 3'h2);
      for (int i = 0; i < 400; i++)
      begin
        if ($urandom % 4 != 0) a = base[$urandom % 10] + ($urandom &
          (($urandom % 2) ? 32'h0000_ffff : 32'h0033_ffff));
        mix = ($urandom % 16 == 0);
        f = 1'($urandom);
        step($urandom % 8 != 0, a, !f && 1'($urandom), f, 1'($urandom), 3'h1 << ($urandom % 3));
      end
    end
    mix = 0;
    step(0, 0, 0, 0, 0, 3'h2);
    step(0, 0, 0, 0, 0, 3'h2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
